//--- pkg/rdc_map.svh
// Address map, field positions, reset values and timing figures of the discrepancy checker.
`ifndef RDC_MAP_SVH
`define RDC_MAP_SVH
`define RDC_NCH          6
`define RDC_NPAIR        3
`define RDC_HIST_AW      6
`define RDC_SUM_W        22
`define RDC_ADDR_W       5
`define RDC_REG_CTRL     5'h00
`define RDC_REG_EVAL     5'h01
`define RDC_REG_PCFG0    5'h02
`define RDC_REG_DTIME0   5'h05
`define RDC_REG_STAT     5'h08
`define RDC_REG_ACK      5'h09
`define RDC_REG_CHVAL0   5'h0a
`define RDC_REG_PVAL0    5'h10
`define RDC_CTRL_SMO     1:0
`define RDC_CTRL_PASSCH  2
`define RDC_CTRL_IRQEN   3
`define RDC_CTRL_RST     4'h0
`define RDC_EVAL_RST     12'h000
`define RDC_EV_SINGLE    2'h0
`define RDC_EV_PAIRED    2'h1
`define RDC_EV_OFF       2'h2
`define RDC_PCFG_ABS     7:0
`define RDC_PCFG_REL     15:8
`define RDC_PCFG_ABSEN   16
`define RDC_PCFG_RELEN   17
`define RDC_PCFG_MAX     18
`define RDC_PCFG_RST     19'h3_1919
`define RDC_TOL_MIN      8'h02
`define RDC_TOL_MAX      8'hc8
`define RDC_TOL_DIV      32'h0000_03e8
`define RDC_SPAN         32'h0000_6c00
`define RDC_FAULT_VAL    16'h7fff
`define RDC_DT_MS_MAX    32'h0000_7530
`define RDC_DT_RST       12'h00f
`define RDC_DT_STEP_MS   10
`define RDC_DT_HALF      32'h0000_0005
`define RDC_DT_MIN       12'h001
`define RDC_CLK_KHZ      125000
`endif

//--- pkg/rdc_mem_if.sv
// Port bundle between the checker core and its sample history memory.
`timescale 1ns/1ns
`default_nettype none
interface rdc_mem_if;
  logic        we;
  logic [8:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- pkg/rdc_pkg.sv
// Types shared by the discrepancy checker modules.
package rdc_pkg;
  typedef enum logic [2:0] {
    RDC_IDLE = 3'b001,
    RDC_READ = 3'b010,
    RDC_UPD  = 3'b100
  } rdc_st_e;
  typedef logic [15:0] rdc_val_t;
  typedef struct packed {
    rdc_st_e          st;
    logic [2:0]       ch;
    rdc_val_t         data;
    logic             flt;
    logic [5:0][5:0]  ptr;
    logic [5:0][6:0]  cnt;
    logic [5:0][21:0] sum;
    logic [3:0]       ctrl;
    logic [11:0]      eval;
    logic [2:0][18:0] pcfg;
    logic [2:0][11:0] dtk;
    logic [2:0][11:0] tmr;
    logic [2:0]       disc;
    logic [2:0]       err;
    logic [2:0]       ackq;
    logic [2:0]       hvld;
    logic [2:0][15:0] held;
    logic [2:0][15:0] pval;
    logic [5:0]       pas;
    logic [20:0]      tick_cnt;
    logic             tick;
    logic             irq;
    logic             ack;
    logic [31:0]      rdata;
  } rdc_state_s;
  typedef struct packed {
    rdc_val_t rdata;
  } rdc_mem_s;
endpackage

//--- src/rdc_core.sv
// Smoothing and two-channel discrepancy evaluation with Avalon-MM register access.
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "rdc_map.svh"
module rdc_core
  import rdc_pkg::*;
#(
  parameter int TICK_CYC = `RDC_DT_STEP_MS * `RDC_CLK_KHZ
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        smp_valid_i,
  input  wire logic [2:0]  smp_ch_i,
  input  wire logic [15:0] smp_data_i,
  input  wire logic        smp_fault_i,
  output logic             smp_ready_o,
  input  wire logic        cyc_i,
  output logic [5:0]       passivate_o,
  output logic             diag_irq_o
);
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [6:0] smo_n(input logic [1:0] sel);
    smo_n = 7'h01 << {sel, 1'b0};
  endfunction

  function automatic rdc_val_t mean(input logic [21:0] sum, input logic [1:0] sel);
    logic [21:0] q;
    q    = sum >> {sel, 1'b0};
    mean = q[15:0];
  endfunction

  function automatic logic [31:0] tol(input rdc_val_t base, input logic [18:0] cfg);
    logic [31:0] ta;
    logic [31:0] tr;
    ta  = cfg[`RDC_PCFG_ABSEN] ? (`RDC_SPAN * 32'(cfg[`RDC_PCFG_ABS])) / `RDC_TOL_DIV : '0;
    tr  = cfg[`RDC_PCFG_RELEN] ? (32'(base) * 32'(cfg[`RDC_PCFG_REL])) / `RDC_TOL_DIV : '0;
    tol = (ta > tr) ? ta : tr;
  endfunction

  function automatic logic [7:0] clamp_tol(input logic [7:0] t);
    clamp_tol = (t < `RDC_TOL_MIN) ? `RDC_TOL_MIN : ((t > `RDC_TOL_MAX) ? `RDC_TOL_MAX : t);
  endfunction

  function automatic logic [5:0] off_mask(input logic [11:0] ev);
    for (int c = 0; c < `RDC_NCH; c++)
      off_mask[c] = ev[2*c +: 2] == `RDC_EV_OFF;
  endfunction

  rdc_state_s        s_r;
  rdc_state_s        s_nxt;
  rdc_mem_if         mif ();
  logic [5:0]        ch_ok;
  rdc_val_t [5:0]    ch_mean;
  logic [2:0]        dcur;
  logic [2:0]        pair_ok;
  logic [2:0]        paired;
  rdc_val_t [2:0]    selv;
  logic              acc;
  logic [4:0]        ra;
  logic [6:0]        wlen;

  rdc_hist_mem u_mem (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .mp    (mif.mem)
  );

  // ---------------------------------------------------------------------------
  // Channel and pair evaluation
  // ---------------------------------------------------------------------------
  always_comb
  begin
    for (int c = 0; c < `RDC_NCH; c++)
    begin
      ch_mean[c] = mean(s_r.sum[c], s_r.ctrl[`RDC_CTRL_SMO]);
      ch_ok[c]   = (s_r.cnt[c] == smo_n(s_r.ctrl[`RDC_CTRL_SMO]))
                   && (s_r.eval[2*c +: 2] != `RDC_EV_OFF);
    end
    for (int p = 0; p < `RDC_NPAIR; p++)
    begin
      rdc_val_t oth;
      rdc_val_t lo;
      rdc_val_t hi;
      logic [15:0] dif;
      lo = (ch_mean[2*p] < ch_mean[2*p+1]) ? ch_mean[2*p] : ch_mean[2*p+1];
      hi = (ch_mean[2*p] < ch_mean[2*p+1]) ? ch_mean[2*p+1] : ch_mean[2*p];
      selv[p]    = s_r.pcfg[p][`RDC_PCFG_MAX] ? hi : lo;
      oth        = s_r.pcfg[p][`RDC_PCFG_MAX] ? lo : hi;
      dif        = (selv[p] > oth) ? selv[p] - oth : oth - selv[p];
      dcur[p]    = 32'(dif) > tol(selv[p], s_r.pcfg[p]);
      pair_ok[p] = ch_ok[2*p] && ch_ok[2*p+1];
      paired[p]  = s_r.eval[4*p +: 2] == `RDC_EV_PAIRED;
    end
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // A request is served in its second cycle, where waitrequest is low.
  assign acc  = (avs_read_i || avs_write_i) && s_r.ack;
  assign ra   = avs_address_i;
  assign wlen = smo_n(s_r.ctrl[`RDC_CTRL_SMO]);

  always_comb
  begin
    logic [6:0]  n;
    logic [31:0] ms;
    logic [31:0] tk;
    logic        exp;
    s_nxt = s_r;
    n     = smo_n(s_r.ctrl[`RDC_CTRL_SMO]);
    ms    = '0;
    tk    = '0;
    exp   = 1'b0;
    s_nxt.ack  = (avs_read_i || avs_write_i) && !s_r.ack;
    s_nxt.tick = (s_r.tick_cnt == 21'(TICK_CYC - 1));
    s_nxt.tick_cnt = s_nxt.tick ? '0 : s_r.tick_cnt + 21'h1;
    // Sample path; the history memory is touched only here, never by the pair logic.
    case (s_r.st)
      RDC_IDLE:
      begin
        if (smp_valid_i)
        begin
          s_nxt.ch   = smp_ch_i;
          s_nxt.data = smp_data_i;
          s_nxt.flt  = smp_fault_i;
          s_nxt.st   = RDC_READ;
        end
      end
      RDC_READ:
      begin
        s_nxt.st = RDC_UPD;
      end
      RDC_UPD:
      begin
        s_nxt.st = RDC_IDLE;
        if (s_r.flt)
        begin
          s_nxt.cnt[s_r.ch] = '0;
          s_nxt.sum[s_r.ch] = '0;
        end
        else
        begin
          s_nxt.sum[s_r.ch] = s_r.sum[s_r.ch] + 22'(s_r.data)
                              - ((s_r.cnt[s_r.ch] == n) ? 22'(mif.rdata) : 22'h0);
          s_nxt.ptr[s_r.ch] = s_r.ptr[s_r.ch] + 6'h1;
          if (s_r.cnt[s_r.ch] != n)
          begin
            s_nxt.cnt[s_r.ch] = s_r.cnt[s_r.ch] + 7'h1;
          end
        end
      end
      default:
      begin
        s_nxt.st = RDC_IDLE;
      end
    endcase
    // Discrepancy timers advance in 10 ms steps; evaluation waits for the conversion strobe.
    for (int p = 0; p < `RDC_NPAIR; p++)
    begin
      if (s_r.tick && s_r.disc[p] && (s_r.tmr[p] != 12'hfff))
      begin
        s_nxt.tmr[p] = s_r.tmr[p] + 12'h1;
      end
      if (acc && avs_write_i && (ra == `RDC_REG_ACK) && avs_writedata_i[p])
      begin
        s_nxt.err[p]  = 1'b0;
        s_nxt.ackq[p] = 1'b0;
        s_nxt.disc[p] = 1'b0;
        s_nxt.tmr[p]  = '0;
      end
      if (cyc_i && paired[p])
      begin
        exp = (s_r.disc[p] ? s_r.tmr[p] : 12'h0) >= s_r.dtk[p];
        if (!pair_ok[p])
        begin
          s_nxt.pval[p] = `RDC_FAULT_VAL;
          s_nxt.hvld[p] = 1'b0;
          s_nxt.disc[p] = 1'b0;
          s_nxt.tmr[p]  = '0;
        end
        else if (s_r.err[p])
        begin
          s_nxt.pval[p] = `RDC_FAULT_VAL;
        end
        else if (dcur[p])
        begin
          s_nxt.disc[p] = 1'b1;
          if (!s_r.disc[p])
          begin
            s_nxt.tmr[p] = '0;
          end
          if (exp)
          begin
            s_nxt.err[p]  = 1'b1;
            s_nxt.pval[p] = `RDC_FAULT_VAL;
          end
          else
          begin
            s_nxt.pval[p] = s_r.hvld[p] ? s_r.held[p] : `RDC_FAULT_VAL;
          end
        end
        else
        begin
          if (s_r.disc[p] && exp)
          begin
            s_nxt.ackq[p] = 1'b1;
          end
          s_nxt.disc[p] = 1'b0;
          s_nxt.tmr[p]  = '0;
          s_nxt.pval[p] = selv[p];
          s_nxt.held[p] = selv[p];
          s_nxt.hvld[p] = 1'b1;
        end
      end
      else if (!paired[p])
      begin
        s_nxt.disc[p] = 1'b0;
        s_nxt.tmr[p]  = '0;
        s_nxt.err[p]  = 1'b0;
      end
    end
    for (int c = 0; c < `RDC_NCH; c++)
    begin
      s_nxt.pas[c] = s_r.ctrl[`RDC_CTRL_PASSCH]
                     ? (!ch_ok[c] || s_r.err[c/2])
                     : ((ch_ok | off_mask(s_r.eval)) != 6'h3f || (s_r.err != '0));
    end
    s_nxt.irq = s_r.ctrl[`RDC_CTRL_IRQEN] && (s_r.err != '0);
    // Register writes take effect at the edge where waitrequest is low.
    if (acc && avs_write_i)
    begin
      if (ra == `RDC_REG_CTRL)
      begin
        s_nxt.ctrl = avs_writedata_i[3:0];
        if (avs_writedata_i[1:0] != s_r.ctrl[`RDC_CTRL_SMO])
        begin
          s_nxt.cnt = '0;
          s_nxt.sum = '0;
        end
      end
      if (ra == `RDC_REG_EVAL)
      begin
        s_nxt.eval = avs_writedata_i[11:0];
      end
      for (int p = 0; p < `RDC_NPAIR; p++)
      begin
        if (ra == `RDC_REG_PCFG0 + 5'(p))
        begin
          s_nxt.pcfg[p] = {avs_writedata_i[18:16], clamp_tol(avs_writedata_i[15:8]),
                           clamp_tol(avs_writedata_i[7:0])};
        end
        if (ra == `RDC_REG_DTIME0 + 5'(p))
        begin
          ms = (avs_writedata_i > `RDC_DT_MS_MAX) ? `RDC_DT_MS_MAX : avs_writedata_i;
          tk = (ms + `RDC_DT_HALF) / `RDC_DT_STEP_MS;
          s_nxt.dtk[p] = ((ms != '0) && (tk[11:0] < `RDC_DT_MIN)) ? `RDC_DT_MIN : tk[11:0];
        end
      end
    end
    // Read data are formed one cycle ahead so that they stand when waitrequest drops.
    s_nxt.rdata = '0;
    if (ra == `RDC_REG_CTRL)
      s_nxt.rdata = {28'h0, s_r.ctrl};
    if (ra == `RDC_REG_EVAL)
      s_nxt.rdata = {20'h0, s_r.eval};
    if (ra == `RDC_REG_STAT)
      s_nxt.rdata = {17'h0, s_r.pas, s_r.ackq, s_r.disc, s_r.err};
    for (int p = 0; p < `RDC_NPAIR; p++)
    begin
      if (ra == `RDC_REG_PCFG0 + 5'(p))
        s_nxt.rdata = {13'h0, s_r.pcfg[p]};
      if (ra == `RDC_REG_DTIME0 + 5'(p))
        s_nxt.rdata = 32'(s_r.dtk[p]) * `RDC_DT_STEP_MS;
      if (ra == `RDC_REG_PVAL0 + 5'(p))
        s_nxt.rdata = {16'h0, s_r.pas[2*p] ? `RDC_FAULT_VAL : s_r.pval[p]};
    end
    for (int c = 0; c < `RDC_NCH; c++)
    begin
      if (ra == `RDC_REG_CHVAL0 + 5'(c))
        s_nxt.rdata = {16'h0, (s_r.pas[c] || !ch_ok[c]) ? `RDC_FAULT_VAL : ch_mean[c]};
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r      <= '0;
      s_r.st   <= RDC_IDLE;
      s_r.ctrl <= `RDC_CTRL_RST;
      s_r.eval <= `RDC_EVAL_RST;
      s_r.pcfg <= {`RDC_NPAIR{`RDC_PCFG_RST}};
      s_r.dtk  <= {`RDC_NPAIR{`RDC_DT_RST}};
      s_r.pval <= {`RDC_NPAIR{`RDC_FAULT_VAL}};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign mif.we            = (s_r.st == RDC_UPD) && !s_r.flt;
  assign mif.wdata         = s_r.data;
  assign mif.addr          = (s_r.st == RDC_UPD) ? {s_r.ch, s_r.ptr[s_r.ch]}
                             : {s_r.ch, s_r.ptr[s_r.ch] - wlen[5:0]};
  assign smp_ready_o       = s_r.st == RDC_IDLE;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s_r.ack;
  assign avs_readdata_o    = s_r.rdata;
  assign passivate_o       = s_r.pas;
  assign diag_irq_o        = s_r.irq;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_err_fault;
    $rose(s_r.err[0]) |-> s_r.pval[0] == `RDC_FAULT_VAL;
  endproperty
  a_err_fault: assert property (p_err_fault) else $error("error without fault value");

  property p_unpaired;
    !paired[0] |=> !s_r.err[0] && !s_r.disc[0];
  endproperty
  a_unpaired: assert property (p_unpaired) else $error("unpaired pair checked");

  property p_pass1;
    logic [2:0] c;
    logic [15:0] d;
    ((s_r.st == RDC_UPD) && !s_r.flt && (s_r.ctrl[1:0] == 2'h0), c = s_r.ch, d = s_r.data)
      |=> ch_mean[c] == d;
  endproperty
  a_pass1: assert property (p_pass1) else $error("unsmoothed sample altered");

  property p_restart;
    logic [2:0] c;
    ((s_r.st == RDC_UPD) && s_r.flt, c = s_r.ch) |=> s_r.cnt[c] == 7'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("averaging not restarted");

  property p_irq;
    (s_r.err != 3'h0) && s_r.ctrl[`RDC_CTRL_IRQEN] |=> diag_irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("diagnostic interrupt missing");

  property p_dtime;
    logic [31:0] w;
    (acc && avs_write_i && (ra == `RDC_REG_DTIME0) && (avs_writedata_i >= 32'd10)
      && (avs_writedata_i <= 32'd30000), w = avs_writedata_i)
      |=> 32'(s_r.dtk[0]) == (w + 32'd5) / 32'd10;
  endproperty
  a_dtime: assert property (p_dtime) else $error("discrepancy time not rounded");

  property p_tol;
    (s_r.pcfg[1][7:0] >= 8'h02) && (s_r.pcfg[1][7:0] <= 8'hc8)
      && (s_r.pcfg[1][15:8] >= 8'h02) && (s_r.pcfg[1][15:8] <= 8'hc8);
  endproperty
  a_tol: assert property (p_tol) else $error("tolerance out of range");

  property p_clear;
    cyc_i && paired[0] && pair_ok[0] && !dcur[0] && !s_r.err[0] |=> !s_r.disc[0]
      && (s_r.tmr[0] == 12'h0) && (s_r.pval[0] == $past(selv[0]));
  endproperty
  a_clear: assert property (p_clear) else $error("timer not cleared");

  property p_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");

  c_err:  cover property ($rose(s_r.err[0]));
  c_ackq: cover property ($rose(s_r.ackq[0]));
  c_disc: cover property ($rose(s_r.disc[0]) ##[1:50] $fell(s_r.disc[0]));
endmodule // rdc_core
`default_nettype wire

//--- src/rdc_hist_mem.sv
// Sample history memory: one window of past samples per channel, registered read.
`timescale 1ns/1ns
`default_nettype none
module rdc_hist_mem
  import rdc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  rdc_mem_if.mem    mp
);
  // Read happens before write, so an address read and written in one cycle yields old data.
  logic [15:0] mem_q [0:511];
  rdc_mem_s    s_r;
  rdc_mem_s    s_nxt;

  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.rdata = mem_q[mp.addr];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
    if (mp.we)
    begin
      mem_q[mp.addr] <= mp.wdata;
    end
  end

  assign mp.rdata = s_r.rdata;
endmodule // rdc_hist_mem
`default_nettype wire

//--- verif/rdc_smp_src.sv
// Converter-side sample source model feeding the checker core.
`timescale 1ns/1ns
`default_nettype none
module rdc_smp_src
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic [2:0]  ch_i,
  input  wire logic [15:0] data_i,
  input  wire logic        fault_i,
  input  wire logic        smp_ready_i,
  output logic             smp_valid_o,
  output logic [2:0]       smp_ch_o,
  output logic [15:0]      smp_data_o,
  output logic             smp_fault_o
);
  // ----------------------------------------------------------------
  // Sample handshake.
  // ----------------------------------------------------------------
  // The sample is held until taken; afterwards the data lines are inverted
  // so that a stale value can never pass for a fresh one.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      smp_valid_o <= 1'b0;
      smp_ch_o    <= 3'h0;
      smp_data_o  <= 16'h0000;
      smp_fault_o <= 1'b0;
    end
    else if (go_i)
    begin
      smp_valid_o <= 1'b1;
      smp_ch_o    <= ch_i;
      smp_data_o  <= data_i;
      smp_fault_o <= fault_i;
    end
    else if (smp_valid_o && smp_ready_i)
    begin
      smp_valid_o <= 1'b0;
      smp_data_o  <= ~smp_data_o;
      smp_fault_o <= ~smp_fault_o;
    end
  end
endmodule // rdc_smp_src
`default_nettype wire

//--- verif/tb_redundant_input_discrepancy_check.sv
// Self-checking testbench of the discrepancy checker core.
`timescale 1ns/1ns
`default_nettype none
`include "rdc_map.svh"
module tb_redundant_input_discrepancy_check;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [4:0]  adr   = 5'h00;
  logic [31:0] wdat  = 32'h0;
  logic        rd    = 1'b0;
  logic        wr    = 1'b0;
  logic        cyc   = 1'b0;
  logic        go    = 1'b0;
  logic        gflt  = 1'b0;
  logic [2:0]  gch   = 3'h0;
  logic [15:0] gdat  = 16'h0;
  wire logic [31:0] rdat;
  wire logic        wreq;
  wire logic        sv;
  wire logic        sflt;
  wire logic        srdy;
  wire logic        irq;
  wire logic [2:0]  sch;
  wire logic [15:0] sdat;
  wire logic [5:0]  pas;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          dts[5] = '{0, 3, 14, 15, 50};
  logic [31:0] seed = 32'h758f;
  logic [31:0] q, a, b, s;

  rdc_core #(.TICK_CYC(10)) i_rdc_core (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .smp_valid_i(sv), .smp_ch_i(sch), .smp_data_i(sdat), .smp_fault_i(sflt),
    .smp_ready_o(srdy), .cyc_i(cyc), .passivate_o(pas), .diag_irq_o(irq));

  rdc_smp_src i_rdc_smp_src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
    .ch_i(gch), .data_i(gdat), .fault_i(gflt), .smp_ready_i(srdy),
    .smp_valid_o(sv), .smp_ch_o(sch), .smp_data_o(sdat), .smp_fault_o(sflt));

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xr();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] dt_exp(input logic [31:0] ms);
    logic [31:0] r;
    r = (ms + `RDC_DT_HALF) / `RDC_DT_STEP_MS * `RDC_DT_STEP_MS;
    if (ms != 0 && r == 0)
      r = `RDC_DT_STEP_MS;
    return r;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // The request stands until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    adr  <= ad;
    wdat <= d;
    wr   <= w;
    rd   <= !w;
    @(posedge clk_i);
    for (k = 0; k < 50 && wreq !== 1'b0; k++)
      @(posedge clk_i);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 50)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  task automatic rd_chk(input string nm, input logic [4:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    chk(nm, e, q);
  endtask

  task automatic send(input logic [2:0] c, input logic [15:0] d, input logic f);
    @(posedge clk_i);
    go   <= 1'b1;
    gch  <= c;
    gdat <= d;
    gflt <= f;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      @(posedge clk_i);
      cyc <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles; this leaves wide margin.
  initial
  begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Stimulus and checks.
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl", `RDC_REG_CTRL, 32'h0);
    rd_chk("eval", `RDC_REG_EVAL, 32'h0);
    rd_chk("pcfg", `RDC_REG_PCFG0, `RDC_PCFG_RST);
    rd_chk("dtime", `RDC_REG_DTIME0, `RDC_DT_RST * `RDC_DT_STEP_MS);
    rd_chk("unmapped", 5'h1f, 32'h0);
    foreach (dts[i])
    begin
      bus(1'b1, 5'h06, dts[i]);
      rd_chk("dtime_round", 5'h06, dt_exp(dts[i]));
    end
    bus(1'b1, 5'h03, 32'h3_ff01);
    rd_chk("clamp", 5'h03, {13'h0, 3'h3, `RDC_TOL_MAX, `RDC_TOL_MIN});
    bus(1'b1, `RDC_REG_CTRL, 32'hc);
    for (int i = 0; i < 6; i++)
    begin
      a = xr() % `RDC_SPAN;
      send(i[2:0], a[15:0], 1'b0);
      pulse(1);
      rd_chk("chval", `RDC_REG_CHVAL0 + i[4:0], a);
    end
    // No conversion cycle runs between pairing and fresh samples, so the
    // first evaluation never sees leftover discrepant values.
    bus(1'b1, `RDC_REG_EVAL, 32'h1);
    bus(1'b1, `RDC_REG_DTIME0, 32'd50);
    for (int m = 0; m < 2; m++)
    begin
      bus(1'b1, `RDC_REG_PCFG0, `RDC_PCFG_RST | (m << 18));
      a = 1000 + xr() % 8000;
      b = a + xr() % 600;
      send(3'h0, a[15:0], 1'b0);
      send(3'h1, b[15:0], 1'b0);
      pulse(2);
      rd_chk("pval", `RDC_REG_PVAL0, m ? b : a);
    end
    send(3'h1, a[15:0] + 16'd3000, 1'b0);
    pulse(1);
    rd_chk("disc", `RDC_REG_STAT, 32'h8);
    rd_chk("hold", `RDC_REG_PVAL0, b);
    send(3'h1, b[15:0], 1'b0);
    pulse(1);
    rd_chk("back", `RDC_REG_STAT, 32'h0);
    pulse(16);
    rd_chk("noerr", `RDC_REG_STAT, 32'h0);
    send(3'h1, a[15:0] + 16'd3000, 1'b0);
    pulse(16);
    bus(1'b0, `RDC_REG_STAT, 32'h0);
    chk("err", 32'h1, q & 32'h1);
    rd_chk("fault", `RDC_REG_PVAL0, `RDC_FAULT_VAL);
    chk("irq", 32'h1, {31'h0, irq});
    send(3'h1, b[15:0], 1'b0);
    pulse(1);
    bus(1'b1, `RDC_REG_ACK, 32'h1);
    bus(1'b0, `RDC_REG_STAT, 32'h0);
    chk("ack", 32'h0, q & 32'h1);
    bus(1'b1, `RDC_REG_CTRL, 32'h5);
    s = 0;
    for (int i = 0; i < 4; i++)
    begin
      a = xr() % `RDC_SPAN;
      s += a;
      send(3'h2, a[15:0], 1'b0);
    end
    pulse(1);
    rd_chk("mean", `RDC_REG_CHVAL0 + 5'h2, s / 4);
    bus(1'b1, `RDC_REG_CTRL, 32'h4);
    for (int i = 0; i < 6; i++)
      send(i[2:0], 16'h0100, i == 2);
    chk("pas_ch", 32'h4, {26'h0, pas});
    bus(1'b1, `RDC_REG_CTRL, 32'h0);
    send(3'h4, 16'h0100, 1'b1);
    chk("pas_mod", 32'h3f, {26'h0, pas});
    tally_and_finish();
  end
endmodule // tb_redundant_input_discrepancy_check
`default_nettype wire
